// [hdl/dcsw_drive_ctrl.sv]
`timescale 1ns/1ps
module dcsw_drive_ctrl
   import dcsw_pkg::*;
#(
   parameter int                  W        = 16,
   parameter int                  PW       = 16,
   parameter logic signed [W-1:0] MOP_MAX  = 16'sh4000,
   parameter logic signed [W-1:0] MOP_STEP = 16'sh0001
) (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   input  wire logic                cmd_valid,
   input  wire logic [CW_W-1:0]     drive_command_word,
   input  wire logic                power_ok,
   input  wire logic                init_done,
   input  wire logic                fault_event,
   input  wire logic                alarm_active,
   input  wire logic                speed_in_tol,
   input  wire logic                master_ctrl_req,
   input  wire logic                cmp_speed_reached,
   input  wire logic                torque_below_cmp,
   input  wire logic                motor_overtemp,
   input  wire logic                inverter_overload,
   input  wire logic signed [W-1:0] actual_value,
   input  wire logic [PW-1:0]       ramp_up_time_setting,
   input  wire logic [PW-1:0]       ramp_down_time_setting,
   input  wire logic [PW-1:0]       quick_stop_ramp_time_setting,
   output logic [CW_W-1:0]          drive_state_word,
   output logic                     pulse_enable,
   output logic signed [W-1:0]      ramp_out,
   output logic signed [W-1:0]      mop_value
);

   dcsw_state_t         state_q;
   dcsw_state_t         state_d;
   logic [CW_W-1:0]     cmd_q;
   logic [CW_W-1:0]     state_word_q;
   logic                on_prev_q;
   logic                ack_prev_q;
   logic                fault_q;
   logic                dir_q;
   logic                pulse_enable_q;
   logic signed [W-1:0] mop_q;
   logic signed [W-1:0] setpoint;
   logic signed [W-1:0] ramp_target;
   logic                on_rise;
   logic                ack_rise;
   logic                stops_ok;
   logic                force_zero;
   logic                ramp_hold;
   logic                quick_sel;
   logic                at_zero;

   function automatic logic pulsing(input dcsw_state_t s);
      pulsing = (s == ST_RUN) || (s == ST_RAMP_STOP) || (s == ST_QUICK_STOP);
   endfunction

   // saturating potentiometer step, symmetric limits
   function automatic logic signed [W-1:0] mop_next(input logic signed [W-1:0] v,
                                                    input logic                up);
      if (up) begin
         mop_next = (v > MOP_MAX - MOP_STEP) ? MOP_MAX : v + MOP_STEP;
      end else begin
         mop_next = (v < MOP_STEP - MOP_MAX) ? -MOP_MAX : v - MOP_STEP;
      end
   endfunction

   assign on_rise  = cmd_q[CB_ON] && !on_prev_q;
   assign ack_rise = cmd_q[CB_ACK] && !ack_prev_q;
   assign stops_ok = cmd_q[CB_NO_COAST] && cmd_q[CB_NO_QUICK];

   // latched word only changes when the controller claims control
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= CMD_RESET;
      end else if (clk_en) begin
         if (cmd_valid && drive_command_word[CB_REMOTE]) begin
            cmd_q <= drive_command_word & CMD_MASK;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         on_prev_q  <= 1'b0;
         ack_prev_q <= 1'b0;
      end else if (clk_en) begin
         on_prev_q  <= cmd_q[CB_ON];
         ack_prev_q <= cmd_q[CB_ACK];
      end
   end

   // new fault in the acknowledge cycle wins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fault_q <= 1'b0;
      end else if (clk_en) begin
         if (fault_event) begin
            fault_q <= 1'b1;
         end else if (ack_rise) begin
            fault_q <= 1'b0;
         end
      end
   end

   always_comb begin
      state_d = state_q;
      if (fault_event) begin
         state_d = ST_FAULT;
      end else if (!power_ok) begin
         state_d = ST_INIT;
      end else begin
         case (state_q)
            ST_INIT: begin
               if (init_done) begin
                  state_d = ST_LOCKOUT;
               end
            end
            ST_LOCKOUT: begin
               if (!cmd_q[CB_ON] && stops_ok) begin
                  state_d = ST_START_RDY;
               end
            end
            ST_START_RDY: begin
               if (!stops_ok) begin
                  state_d = ST_LOCKOUT;
               end else if (on_rise) begin
                  state_d = ST_READY;
               end
            end
            ST_READY: begin
               if (!stops_ok) begin
                  state_d = ST_LOCKOUT;
               end else if (!cmd_q[CB_ON]) begin
                  state_d = ST_START_RDY;
               end else if (cmd_q[CB_ENABLE]) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (!cmd_q[CB_NO_COAST]) begin
                  state_d = ST_LOCKOUT;
               end else if (!cmd_q[CB_ENABLE]) begin
                  state_d = ST_READY;
               end else if (!cmd_q[CB_NO_QUICK]) begin
                  state_d = ST_QUICK_STOP;
               end else if (!cmd_q[CB_ON]) begin
                  state_d = ST_RAMP_STOP;
               end
            end
            ST_RAMP_STOP: begin
               if (!cmd_q[CB_NO_COAST]) begin
                  state_d = ST_LOCKOUT;
               end else if (!cmd_q[CB_ENABLE] || (at_zero && cmd_q[CB_NO_QUICK])) begin
                  state_d = ST_START_RDY;
               end else if (!cmd_q[CB_NO_QUICK]) begin
                  state_d = ST_QUICK_STOP;
               end
            end
            ST_QUICK_STOP: begin
               if (!cmd_q[CB_NO_COAST] || !cmd_q[CB_ENABLE] || at_zero) begin
                  state_d = ST_LOCKOUT;
               end
            end
            ST_FAULT: begin
               if (ack_rise) begin
                  state_d = (cmd_q[CB_ON] || !stops_ok) ? ST_LOCKOUT : ST_START_RDY;
               end
            end
            default: begin
               state_d = ST_INIT;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_INIT;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // registered from the next state so pulses drop in the same edge as the state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pulse_enable_q <= 1'b0;
      end else if (clk_en) begin
         pulse_enable_q <= pulsing(state_d);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mop_q <= '0;
      end else if (clk_en) begin
         // both buttons at once: no change
         if (cmd_q[CB_MOP_UP] && !cmd_q[CB_MOP_DN]) begin
            mop_q <= mop_next(mop_q, 1'b1);
         end else if (cmd_q[CB_MOP_DN] && !cmd_q[CB_MOP_UP]) begin
            mop_q <= mop_next(mop_q, 1'b0);
         end
      end
   end

   assign setpoint    = cmd_q[CB_REVERSE] ? -mop_q : mop_q;
   assign ramp_target = (state_q == ST_RUN && cmd_q[CB_SP_EN]) ? setpoint : '0;
   assign force_zero  = !pulse_enable_q || !cmd_q[CB_RFG_EN];
   assign ramp_hold   = (state_q == ST_RUN) && !cmd_q[CB_RFG_RUN];
   assign quick_sel   = (state_q == ST_QUICK_STOP);

   dcsw_ramp #(
      .W  (W),
      .PW (PW)
   ) u_ramp (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .clk_en       (clk_en),
      .force_zero   (force_zero),
      .hold         (ramp_hold),
      .quick_sel    (quick_sel),
      .target       (ramp_target),
      .up_period    (ramp_up_time_setting),
      .down_period  (ramp_down_time_setting),
      .quick_period (quick_stop_ramp_time_setting),
      .value        (ramp_out),
      .at_zero      (at_zero)
   );

   // zero actual value keeps the last direction
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= DIR_RESET;
      end else if (clk_en) begin
         if (actual_value > 0) begin
            dir_q <= 1'b1;
         end else if (actual_value < 0) begin
            dir_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_word_q <= STATUS_RESET;
      end else if (clk_en) begin
         state_word_q[SB_START_RDY] <= (state_q == ST_START_RDY);
         state_word_q[SB_READY]     <= (state_q == ST_READY) || (state_q == ST_RUN);
         state_word_q[SB_RUN]       <= (state_q == ST_RUN);
         state_word_q[SB_FAULT]     <= fault_q;
         state_word_q[SB_NO_COAST]  <= cmd_q[CB_NO_COAST];
         state_word_q[SB_NO_QUICK]  <= cmd_q[CB_NO_QUICK];
         state_word_q[SB_LOCKOUT]   <= (state_q == ST_LOCKOUT);
         state_word_q[SB_ALARM]     <= alarm_active;
         state_word_q[SB_SPD_TOL]   <= speed_in_tol;
         state_word_q[SB_MASTER]    <= master_ctrl_req;
         state_word_q[SB_CMP_SPD]   <= cmp_speed_reached;
         state_word_q[SB_TRQ_LOW]   <= torque_below_cmp;
         state_word_q[SB_RSVD]      <= 1'b0;
         state_word_q[SB_MOT_TEMP]  <= !motor_overtemp;
         state_word_q[SB_DIR]       <= dir_q;
         state_word_q[SB_INV_TEMP]  <= !inverter_overload;
      end
   end

   assign drive_state_word = state_word_q;
   assign pulse_enable     = pulse_enable_q;
   assign mop_value        = mop_q;

   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_on_edge;
      clk_en && power_ok && !fault_event && (state_q == ST_START_RDY) && on_rise && stops_ok;
   endsequence
   sequence s_fault_ack;
      clk_en && power_ok && !fault_event && (state_q == ST_FAULT) && ack_rise;
   endsequence

   property p_on_ready;
      s_on_edge |=> (state_q == ST_READY);
   endproperty
   a_on_ready: assert property (p_on_ready) else $error("on edge did not reach ready");

   property p_ack_lockout;
      s_fault_ack ##0 cmd_q[CB_ON] |=> (state_q == ST_LOCKOUT) && !fault_q;
   endproperty
   a_ack_lockout: assert property (p_ack_lockout) else $error("ack with on not locked");

   property p_coast_cut;
      clk_en && !cmd_q[CB_NO_COAST] |=> !pulse_enable_q;
   endproperty
   a_coast_cut: assert property (p_coast_cut) else $error("pulses on during coast stop");

   property p_inhibit;
      clk_en && !cmd_q[CB_ENABLE] |=> !pulse_enable_q;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("pulses on while inhibited");

   property p_rfg_zero;
      clk_en && !cmd_q[CB_RFG_EN] |=> (ramp_out == 0);
   endproperty
   a_rfg_zero: assert property (p_rfg_zero) else $error("ramp not forced to zero");

   property p_hold;
      clk_en && ramp_hold && !force_zero |=> (ramp_out == $past(ramp_out));
   endproperty
   a_hold: assert property (p_hold) else $error("ramp moved while stopped");

   property p_ramp_stop_end;
      clk_en && power_ok && !fault_event && (state_q == ST_RAMP_STOP) && at_zero && stops_ok
      |=> (state_q == ST_START_RDY) && !pulse_enable_q;
   endproperty
   a_ramp_stop_end: assert property (p_ramp_stop_end) else $error("no drop at standstill");

   property p_fault_set;
      clk_en && fault_event |=> fault_q && (state_q == ST_FAULT) && !pulse_enable_q;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not taken");

   property p_fault_hold;
      clk_en && fault_q && !ack_rise |=> fault_q;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault cleared without ack");

   property p_run_status;
      clk_en && (state_q == ST_RUN) |=> drive_state_word[SB_RUN] && drive_state_word[SB_READY];
   endproperty
   a_run_status: assert property (p_run_status) else $error("run status missing");

   property p_ignore;
      clk_en && !(cmd_valid && drive_command_word[CB_REMOTE]) |=> (cmd_q == $past(cmd_q));
   endproperty
   a_ignore: assert property (p_ignore) else $error("word taken without control");

   property p_thermal;
      clk_en ##0 $rose(motor_overtemp) |=> !drive_state_word[SB_MOT_TEMP];
   endproperty
   a_thermal: assert property (p_thermal) else $error("overtemp not flagged");

   property p_mop_up;
      clk_en && cmd_q[CB_MOP_UP] && !cmd_q[CB_MOP_DN] && (mop_q < MOP_MAX) |=> (mop_q > $past(mop_q));
   endproperty
   a_mop_up: assert property (p_mop_up) else $error("pot did not rise");

endmodule

// [hdl/dcsw_pkg.sv]
package dcsw_pkg;

   localparam int CW_W = 16;

   // command word bit positions
   localparam int CB_ON        = 0;
   localparam int CB_NO_COAST  = 1;
   localparam int CB_NO_QUICK  = 2;
   localparam int CB_ENABLE    = 3;
   localparam int CB_RFG_EN    = 4;
   localparam int CB_RFG_RUN   = 5;
   localparam int CB_SP_EN     = 6;
   localparam int CB_ACK       = 7;
   localparam int CB_REMOTE    = 10;
   localparam int CB_REVERSE   = 11;
   localparam int CB_MOP_UP    = 13;
   localparam int CB_MOP_DN    = 14;

   // state word bit positions
   localparam int SB_START_RDY = 0;
   localparam int SB_READY     = 1;
   localparam int SB_RUN       = 2;
   localparam int SB_FAULT     = 3;
   localparam int SB_NO_COAST  = 4;
   localparam int SB_NO_QUICK  = 5;
   localparam int SB_LOCKOUT   = 6;
   localparam int SB_ALARM     = 7;
   localparam int SB_SPD_TOL   = 8;
   localparam int SB_MASTER    = 9;
   localparam int SB_CMP_SPD   = 10;
   localparam int SB_TRQ_LOW   = 11;
   localparam int SB_RSVD      = 12;
   localparam int SB_MOT_TEMP  = 13;
   localparam int SB_DIR       = 14;
   localparam int SB_INV_TEMP  = 15;

   // reserved command bits 8, 9, 12, 15 are dropped
   localparam logic [CW_W-1:0] CMD_MASK     = 16'h6cff;
   localparam logic [CW_W-1:0] CMD_RESET    = 16'h0000;
   localparam logic [CW_W-1:0] STATUS_RESET = 16'he000;
   localparam logic            DIR_RESET    = 1'b1;

   typedef enum logic [7:0] {
      ST_INIT       = 8'h01,
      ST_LOCKOUT    = 8'h02,
      ST_START_RDY  = 8'h04,
      ST_READY      = 8'h08,
      ST_RUN        = 8'h10,
      ST_RAMP_STOP  = 8'h20,
      ST_QUICK_STOP = 8'h40,
      ST_FAULT      = 8'h80
   } dcsw_state_t;

endpackage

// [hdl/dcsw_ramp.sv]
`timescale 1ns/1ps
module dcsw_ramp
   import dcsw_pkg::*;
#(
   parameter int W  = 16,
   parameter int PW = 16
) (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   input  wire logic                force_zero,
   input  wire logic                hold,
   input  wire logic                quick_sel,
   input  wire logic signed [W-1:0] target,
   input  wire logic [PW-1:0]       up_period,
   input  wire logic [PW-1:0]       down_period,
   input  wire logic [PW-1:0]       quick_period,
   output logic signed [W-1:0]      value,
   output logic                     at_zero
);

   logic signed [W-1:0] value_q;
   logic [PW-1:0]       cnt_q;
   logic [PW-1:0]       period;
   logic                accel;

   // moving away from zero uses the up time, towards zero the down time
   assign accel   = ((target > value_q) && (value_q >= 0)) || ((target < value_q) && (value_q <= 0));
   assign period  = quick_sel ? quick_period : (accel ? up_period : down_period);
   assign value   = value_q;
   assign at_zero = (value_q == 0);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         value_q <= '0;
         cnt_q   <= '0;
      end else if (clk_en) begin
         if (force_zero) begin
            value_q <= '0;
            cnt_q   <= '0;
         end else if (hold || (value_q == target)) begin
            cnt_q <= '0;
         end else if (cnt_q >= period) begin
            cnt_q   <= '0;
            value_q <= (target > value_q) ? value_q + W'(1) : value_q - W'(1);
         end else begin
            cnt_q <= cnt_q + PW'(1);
         end
      end
   end

endmodule

// [dv/dcsw_plc_model.sv]
`timescale 1ns/1ps
module dcsw_plc_model
   import dcsw_pkg::*;
(
   input  wire logic        clk_sys,
   output logic             cmd_valid,
   output logic [CW_W-1:0]  drive_command_word
);
   initial begin
      cmd_valid = 1'b0;
      drive_command_word = 16'h0000;
   end

   // one word per call; between words the data lines carry junk
   task automatic send(input logic [CW_W-1:0] w, input bit raw);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      drive_command_word = raw ? w : (w & CMD_MASK);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      drive_command_word = ~drive_command_word;
   endtask
endmodule

// [dv/drive_control_status_word_tb.sv]
`timescale 1ns/1ps
module drive_control_status_word_tb;
   import dcsw_pkg::*;
   logic               clk_sys = 1'b0;
   logic               rst_n = 1'b0;
   logic               power_ok = 1'b0;
   logic               init_done = 1'b0;
   logic               fault_event = 1'b0;
   logic               clk_en = 1'b1;
   logic [6:0]         st_in = 7'h00;
   logic signed [15:0] act_val = 16'sh0001;
   logic [15:0]        t_up = 16'h0000;
   logic [15:0]        t_dn = 16'h0003;
   logic [15:0]        t_q = 16'h0000;
   logic               cmd_valid;
   logic [CW_W-1:0]    cmd_word;
   logic [CW_W-1:0]    drive_state_word;
   logic               pulse_enable;
   logic signed [15:0] ramp_out;
   logic signed [15:0] mop_value;
   logic signed [15:0] m0;
   logic               exp_dir = DIR_RESET;
   logic [31:0]        lfsr = 32'h8fbc;
   int                 n_fail = 0;
   int                 comparisons = 0;

   always #5 clk_sys = ~clk_sys;

   dcsw_plc_model u_plc (
      .clk_sys            (clk_sys),
      .cmd_valid          (cmd_valid),
      .drive_command_word (cmd_word)
   );

   dcsw_drive_ctrl u_dut (
      .clk_sys                      (clk_sys),
      .rst_n                        (rst_n),
      .clk_en                       (clk_en),
      .cmd_valid                    (cmd_valid),
      .drive_command_word           (cmd_word),
      .power_ok                     (power_ok),
      .init_done                    (init_done),
      .fault_event                  (fault_event),
      .alarm_active                 (st_in[0]),
      .speed_in_tol                 (st_in[1]),
      .master_ctrl_req              (st_in[2]),
      .cmp_speed_reached            (st_in[3]),
      .torque_below_cmp             (st_in[4]),
      .motor_overtemp               (st_in[5]),
      .inverter_overload            (st_in[6]),
      .actual_value                 (act_val),
      .ramp_up_time_setting         (t_up),
      .ramp_down_time_setting       (t_dn),
      .quick_stop_ramp_time_setting (t_q),
      .drive_state_word             (drive_state_word),
      .pulse_enable                 (pulse_enable),
      .ramp_out                     (ramp_out),
      .mop_value                    (mop_value)
   );

   function automatic logic [31:0] lfsr_nx(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   // thermal bits are low-true alarms
   function automatic logic [15:0] flags_exp(input logic [6:0] a);
      return {~a[6], 1'b0, ~a[5], 1'b0, a[4:0], 7'h00};
   endfunction

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic go(input logic [15:0] w, input int n);
      u_plc.send(w, 1'b0);
      cyc(n);
   endtask

   initial begin
      cyc(2);
      chk(drive_state_word, STATUS_RESET);
      chk({15'h0, pulse_enable}, 16'h0000);
      cyc(1);
      rst_n = 1'b1;
      power_ok = 1'b1;
      init_done = 1'b1;
      cyc(3);
      chk(drive_state_word & 16'h007f, 16'h0040);
      go(16'h0406, 3);
      chk(drive_state_word & 16'h007f, 16'h0031);
      go(16'h007f, 3);
      chk(drive_state_word & 16'h007f, 16'h0031);
      u_plc.send(16'h9706, 1'b1);
      cyc(3);
      chk(drive_state_word & 16'h007f, 16'h0031);
      go(16'h2406, 3);
      m0 = mop_value;
      cyc(10);
      chk(mop_value, m0 + 16'sd10);
      go(16'h4406, 3);
      m0 = mop_value;
      cyc(4);
      chk(mop_value, m0 - 16'sd4);
      go(16'h0406, 3);
      go(16'h047f, 4);
      chk(drive_state_word & 16'h007f, 16'h0036);
      chk({15'h0, pulse_enable}, 16'h0001);
      cyc(40);
      chk(ramp_out, mop_value);
      // pot keeps rising while the ramp is frozen
      go(16'h245f, 2);
      m0 = ramp_out;
      cyc(8);
      chk(ramp_out, m0);
      go(16'h047f, 40);
      chk(ramp_out, mop_value);
      go(16'h0c7f, 120);
      chk(ramp_out, -mop_value);
      go(16'h0c6f, 1);
      chk(ramp_out, 16'h0000);
      go(16'h047f, 40);
      go(16'h043f, 100);
      chk(ramp_out, 16'h0000);
      chk({15'h0, pulse_enable}, 16'h0001);
      // freeze at zero in run: neither the ramp nor a word sent meanwhile may move anything
      go(16'h043f, 10);
      clk_en = 1'b0;
      m0 = ramp_out;
      u_plc.send(16'h0477, 1'b0);
      cyc(8);
      chk(ramp_out, m0);
      chk({15'h0, pulse_enable}, 16'h0001);
      clk_en = 1'b1;
      cyc(4);
      chk({15'h0, pulse_enable}, 16'h0001);
      go(16'h047f, 40);
      for (int i = 0; i < 24; i++) begin
         lfsr = lfsr_nx(lfsr);
         st_in = lfsr[6:0];
         act_val = (i % 4 == 3) ? 16'sh0000 : lfsr[31:16];
         if (act_val != 16'sh0000) begin
            exp_dir = act_val > 16'sh0000;
         end
         cyc(3);
         chk(drive_state_word & 16'hbf80, flags_exp(st_in));
         chk({15'h0, drive_state_word[SB_DIR]}, {15'h0, exp_dir});
         chk({15'h0, pulse_enable}, 16'h0001);
      end
      st_in = 7'h00;
      go(16'h0477, 1);
      chk({15'h0, pulse_enable}, 16'h0000);
      cyc(2);
      chk(drive_state_word & 16'h0007, 16'h0002);
      go(16'h047f, 40);
      go(16'h047e, 5);
      chk({15'h0, pulse_enable}, 16'h0001);
      cyc(150);
      chk({15'h0, pulse_enable}, 16'h0000);
      chk(drive_state_word & 16'h0007, 16'h0001);
      // quick ramp is four times faster than the normal one here
      go(16'h047f, 40);
      go(16'h047b, 30);
      chk({15'h0, pulse_enable}, 16'h0000);
      chk({15'h0, drive_state_word[SB_NO_QUICK]}, 16'h0000);
      go(16'h0406, 4);
      go(16'h047f, 40);
      go(16'h047d, 1);
      chk({15'h0, pulse_enable}, 16'h0000);
      cyc(2);
      chk(drive_state_word & 16'h0050, 16'h0040);
      go(16'h047f, 4);
      chk(drive_state_word & 16'h0047, 16'h0040);
      go(16'h0406, 4);
      go(16'h047f, 5);
      chk({15'h0, pulse_enable}, 16'h0001);
      fault_event = 1'b1;
      cyc(1);
      fault_event = 1'b0;
      cyc(3);
      chk(drive_state_word & 16'h0008, 16'h0008);
      chk({15'h0, pulse_enable}, 16'h0000);
      go(16'h047f, 4);
      chk(drive_state_word & 16'h0008, 16'h0008);
      go(16'h04ff, 4);
      chk(drive_state_word & 16'h0048, 16'h0040);
      // supply loss while running, then a slow re-initialisation
      go(16'h0406, 4);
      go(16'h047f, 5);
      power_ok = 1'b0;
      cyc(1);
      chk({15'h0, pulse_enable}, 16'h0000);
      cyc(2);
      chk(drive_state_word & 16'h0047, 16'h0000);
      init_done = 1'b0;
      power_ok = 1'b1;
      cyc(3);
      chk(drive_state_word & 16'h0047, 16'h0000);
      init_done = 1'b1;
      cyc(3);
      chk(drive_state_word & 16'h0047, 16'h0040);
      final_report;
   end

   // whole sequence needs about 950 cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      final_report;
   end
endmodule
